// ==== design/rftmc_regs.sv ====
/*
 AXI4-Lite register bank for general and transmit mode configuration.
 Assumes the transmitter and driver consume the decoded outputs and
 a master that keeps AXI4-Lite valid/ready rules.
 // Contract
 // - Location 10h is reserved, no function, reads zero.
 // - General mode register holds order, wait, polarity, preset; resets 3Fh.
 // - Send CRC enable bit 7 makes the sender append a CRC.
 // - Bits 6:4 pick send rate 106/212/424/848; codes 4-7 reserved.
 // - Bit 3 set inverts the send modulation.
 // - Transmit mode register lives at 12h and resets to zero.
 // - Transmit mode bits 2:0 are reserved, no function.
*/
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rftmc_regs (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             crc_bit_order_high_first,
   output logic             wait_for_field_before_send,
   output logic             ext_input_polarity,
   output logic [1:0]       crc_start_value_sel,
   output logic             send_crc_enable,
   output logic [2:0]       send_bit_rate,
   output logic             invert_send_modulation,
   output logic             rate_106,
   output logic             rate_212,
   output logic             rate_424,
   output logic             rate_848,
   output logic             rate_code_reserved
);
   logic [7:0] general_mode_config_reg;
   logic [7:0] transmit_mode_config_reg;
   logic [9:0] aw_addr_reg;
   logic       aw_held_reg;
   logic [31:0] w_data_reg;
   logic        w_strb0_reg;
   logic        w_held_reg;
   logic        do_write;
   logic [7:0]  general_next;
   logic [7:0]  transmit_next;

   function automatic logic mapped(input logic [9:0] a);
      mapped = (a == rftmc_pkg::ADDR_RESERVED) || (a == rftmc_pkg::ADDR_GENERAL) ||
               (a == rftmc_pkg::ADDR_TRANSMIT);
   endfunction

   // Address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 10'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb0_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg  <= 1'b1;
         w_data_reg  <= s_axi_wdata;
         w_strb0_reg <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held_reg <= 1'b0;
      end
   end

   assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= rftmc_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr_reg) ? rftmc_pkg::RESP_OKAY : rftmc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_comb begin
      general_next  = general_mode_config_reg;
      transmit_next = transmit_mode_config_reg;
      if (do_write && w_strb0_reg) begin
         if (aw_addr_reg == rftmc_pkg::ADDR_GENERAL) begin
            // Reserved bits hold their reset value
            general_next = (w_data_reg[7:0] & rftmc_pkg::GEN_WMASK) | rftmc_pkg::GEN_FIXED;
         end
         if (aw_addr_reg == rftmc_pkg::ADDR_TRANSMIT) begin
            // Bits 2:0 are never stored
            transmit_next = w_data_reg[7:0] & rftmc_pkg::TX_WMASK;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         general_mode_config_reg <= rftmc_pkg::RST_GENERAL;
      end else begin
         general_mode_config_reg <= general_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transmit_mode_config_reg <= rftmc_pkg::RST_TRANSMIT;
      end else begin
         transmit_mode_config_reg <= transmit_next;
      end
   end

   // Read channel; reserved slot reads zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= rftmc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= mapped(s_axi_araddr) ? rftmc_pkg::RESP_OKAY : rftmc_pkg::RESP_SLVERR;
         case (s_axi_araddr)
            rftmc_pkg::ADDR_RESERVED: s_axi_rdata <= {24'h000000, rftmc_pkg::RST_RESERVED};
            rftmc_pkg::ADDR_GENERAL:  s_axi_rdata <= {24'h000000, general_mode_config_reg};
            rftmc_pkg::ADDR_TRANSMIT: s_axi_rdata <= {24'h000000, transmit_mode_config_reg};
            default:                  s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Decoded settings, registered for the transmitter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         crc_bit_order_high_first   <= rftmc_pkg::RST_GENERAL[rftmc_pkg::GEN_ORDER_BIT];
         wait_for_field_before_send <= rftmc_pkg::RST_GENERAL[rftmc_pkg::GEN_WAIT_BIT];
         ext_input_polarity         <= rftmc_pkg::RST_GENERAL[rftmc_pkg::GEN_POL_BIT];
         crc_start_value_sel        <= rftmc_pkg::RST_GENERAL[rftmc_pkg::GEN_PRE_LSB +: 2];
         send_crc_enable            <= 1'b0;
         send_bit_rate              <= rftmc_pkg::RATE_106;
         invert_send_modulation     <= 1'b0;
      end else begin
         crc_bit_order_high_first   <= general_next[rftmc_pkg::GEN_ORDER_BIT];
         wait_for_field_before_send <= general_next[rftmc_pkg::GEN_WAIT_BIT];
         ext_input_polarity         <= general_next[rftmc_pkg::GEN_POL_BIT];
         crc_start_value_sel        <= general_next[rftmc_pkg::GEN_PRE_LSB +: 2];
         send_crc_enable            <= transmit_next[rftmc_pkg::TX_CRC_BIT];
         send_bit_rate              <= transmit_next[rftmc_pkg::TX_RATE_LSB +: 3];
         invert_send_modulation     <= transmit_next[rftmc_pkg::TX_INV_BIT];
      end
   end

   // One-hot rate select; reserved codes select none
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rate_106           <= 1'b1;
         rate_212           <= 1'b0;
         rate_424           <= 1'b0;
         rate_848           <= 1'b0;
         rate_code_reserved <= 1'b0;
      end else begin
         rate_106           <= transmit_next[rftmc_pkg::TX_RATE_LSB +: 3] == rftmc_pkg::RATE_106;
         rate_212           <= transmit_next[rftmc_pkg::TX_RATE_LSB +: 3] == rftmc_pkg::RATE_212;
         rate_424           <= transmit_next[rftmc_pkg::TX_RATE_LSB +: 3] == rftmc_pkg::RATE_424;
         rate_848           <= transmit_next[rftmc_pkg::TX_RATE_LSB +: 3] == rftmc_pkg::RATE_848;
         rate_code_reserved <= transmit_next[rftmc_pkg::TX_RATE_LSB + 2];
      end
   end

   // Reserved bits never take a written value
   a_tx_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (transmit_mode_config_reg & ~rftmc_pkg::TX_WMASK) == 8'h00)
      else $error("tx reserved bits set");
   a_gen_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
      (general_mode_config_reg & ~rftmc_pkg::GEN_WMASK) == rftmc_pkg::GEN_FIXED)
      else $error("general reserved bits changed");

   // Reset values
   a_tx_reset: assert property (@(posedge aclk)
      !aresetn |=> transmit_mode_config_reg == rftmc_pkg::RST_TRANSMIT)
      else $error("tx reset value");
   a_gen_reset: assert property (@(posedge aclk)
      !aresetn |=> general_mode_config_reg == rftmc_pkg::RST_GENERAL)
      else $error("general reset value");

   // Register writes land with the masks applied
   a_tx_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb0_reg && aw_addr_reg == rftmc_pkg::ADDR_TRANSMIT
      |=> transmit_mode_config_reg == ($past(w_data_reg[7:0]) & rftmc_pkg::TX_WMASK))
      else $error("tx write lost");
   a_gen_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb0_reg && aw_addr_reg == rftmc_pkg::ADDR_GENERAL
      |=> general_mode_config_reg ==
          (($past(w_data_reg[7:0]) & rftmc_pkg::GEN_WMASK) | rftmc_pkg::GEN_FIXED))
      else $error("general write lost");
   a_strb_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !w_strb0_reg
      |=> $stable(transmit_mode_config_reg) && $stable(general_mode_config_reg))
      else $error("write without byte strobe changed a register");
   a_rsvd_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && aw_addr_reg == rftmc_pkg::ADDR_RESERVED
      |=> $stable(transmit_mode_config_reg) && $stable(general_mode_config_reg))
      else $error("reserved write changed a register");
   a_bad_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !mapped(aw_addr_reg)
      |=> s_axi_bvalid && s_axi_bresp == rftmc_pkg::RESP_SLVERR)
      else $error("unmapped write not refused");
   a_aw_once: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address ready stayed high");
   a_w_once: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
      else $error("data ready stayed high");

   // Read data is the register as it stood when the address was taken
   a_tx_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == rftmc_pkg::ADDR_TRANSMIT
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(transmit_mode_config_reg)})
      else $error("tx read wrong");
   a_gen_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == rftmc_pkg::ADDR_GENERAL
      |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(general_mode_config_reg)})
      else $error("general read wrong");
   a_rsvd_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == rftmc_pkg::ADDR_RESERVED
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000) else $error("reserved not zero");
   a_bad_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr)
      |=> s_axi_rresp == rftmc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
      else $error("unmapped read not refused");

   // Decoded settings track the stored fields
   a_crc_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 send_crc_enable == transmit_mode_config_reg[rftmc_pkg::TX_CRC_BIT])
      else $error("crc enable mismatch");
   a_crc_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb0_reg && aw_addr_reg == rftmc_pkg::ADDR_TRANSMIT
      |=> send_crc_enable == $past(w_data_reg[rftmc_pkg::TX_CRC_BIT]))
      else $error("crc enable not taken from write");
   a_inv_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 invert_send_modulation == transmit_mode_config_reg[rftmc_pkg::TX_INV_BIT])
      else $error("invert mismatch");
   a_inv_write: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && w_strb0_reg && aw_addr_reg == rftmc_pkg::ADDR_TRANSMIT
      |=> invert_send_modulation == $past(w_data_reg[rftmc_pkg::TX_INV_BIT]))
      else $error("invert not taken from write");
   a_rate_field: assert property (@(posedge aclk) disable iff (!aresetn)
      send_bit_rate == transmit_mode_config_reg[rftmc_pkg::TX_RATE_LSB +: 3])
      else $error("rate field mismatch");
   a_rate_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 (rate_848 == (send_bit_rate == rftmc_pkg::RATE_848)) &&
      (rate_106 == (send_bit_rate == rftmc_pkg::RATE_106)))
      else $error("rate decode wrong");
   a_rate_mid: assert property (@(posedge aclk) disable iff (!aresetn)
      (rate_212 == (send_bit_rate == rftmc_pkg::RATE_212)) &&
      (rate_424 == (send_bit_rate == rftmc_pkg::RATE_424)))
      else $error("middle rate decode wrong");
   a_rate_rsvd: assert property (@(posedge aclk) disable iff (!aresetn)
      rate_code_reserved == (send_bit_rate > rftmc_pkg::RATE_848))
      else $error("reserved rate flag wrong");
   a_gen_outs: assert property (@(posedge aclk) disable iff (!aresetn)
      crc_bit_order_high_first == general_mode_config_reg[rftmc_pkg::GEN_ORDER_BIT] &&
      wait_for_field_before_send == general_mode_config_reg[rftmc_pkg::GEN_WAIT_BIT] &&
      ext_input_polarity == general_mode_config_reg[rftmc_pkg::GEN_POL_BIT] &&
      crc_start_value_sel == general_mode_config_reg[rftmc_pkg::GEN_PRE_LSB +: 2])
      else $error("general settings not driven");
endmodule // rftmc_regs
`default_nettype wire

// ==== shared/rftmc_pkg.sv ====
/*
 Constants for the transmit and general mode configuration registers:
 byte offsets, reset values, field positions and bit-rate codes.
 Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
*/
`default_nettype none
package rftmc_pkg;
   // Printed offsets are register indices; byte address is four times
   localparam logic [7:0]  IDX_RESERVED  = 8'h10;
   localparam logic [7:0]  IDX_GENERAL   = 8'h11;
   localparam logic [7:0]  IDX_TRANSMIT  = 8'h12;
   localparam int          ADDR_W        = 10;
   localparam logic [9:0]  ADDR_RESERVED = {IDX_RESERVED, 2'b00};
   localparam logic [9:0]  ADDR_GENERAL  = {IDX_GENERAL, 2'b00};
   localparam logic [9:0]  ADDR_TRANSMIT = {IDX_TRANSMIT, 2'b00};
   localparam logic [7:0]  RST_RESERVED  = 8'h00;
   localparam logic [7:0]  RST_GENERAL   = 8'h3f;
   localparam logic [7:0]  RST_TRANSMIT  = 8'h00;
   // Writable bits of the general mode register (7, 5, 3, 1:0)
   localparam logic [7:0]  GEN_WMASK     = 8'ha3 | 8'h08;
   // Reserved bits of general mode keep their reset value
   localparam logic [7:0]  GEN_FIXED     = RST_GENERAL & ~GEN_WMASK;
   // Writable bits of the transmit mode register (7:3)
   localparam logic [7:0]  TX_WMASK      = 8'hf8;
   localparam int          GEN_ORDER_BIT = 7;
   localparam int          GEN_WAIT_BIT  = 5;
   localparam int          GEN_POL_BIT   = 3;
   localparam int          GEN_PRE_LSB   = 0;
   localparam int          TX_CRC_BIT    = 7;
   localparam int          TX_RATE_LSB   = 4;
   localparam int          TX_INV_BIT    = 3;
   localparam logic [2:0]  RATE_106      = 3'h0;
   localparam logic [2:0]  RATE_212      = 3'h1;
   localparam logic [2:0]  RATE_424      = 3'h2;
   localparam logic [2:0]  RATE_848      = 3'h3;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      RFTMC_R106_T, RFTMC_R212_T, RFTMC_R424_T, RFTMC_R848_T
   } rftmc_rate_t;
endpackage
`default_nettype wire

// ==== test/rftmc_tx_sink.sv ====
/* Sink standing for the sender: turns the rate flags into kbit/s
 and flags a CRC-off setting away from the slowest rate.
 Assumes it sees the register block's decoded outputs. */
`timescale 1ns/1ps
`default_nettype none
module rftmc_tx_sink (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       send_crc_enable,
   input  wire logic       rate_106,
   input  wire logic       rate_212,
   input  wire logic       rate_424,
   input  wire logic       rate_848,
   output logic [9:0]      kbps,
   output logic            misuse
);
   always_comb kbps = rate_848 ? 10'd848 : rate_424 ? 10'd424 :
                      rate_212 ? 10'd212 : rate_106 ? 10'd106 : 10'd0;
   always_ff @(posedge aclk) begin
      if (!aresetn) misuse <= 1'b0;
      else if (!send_crc_enable && !rate_106) misuse <= 1'b1;
   end
endmodule // rftmc_tx_sink
`default_nettype wire

// ==== test/testbench.sv ====
/* Self-checking bench: AXI4-Lite master tasks and a reference model.
 Assumes the package, the register block and the sink are compiled. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        aclk = 0, aresetn = 0;
   logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, crc_start_value_sel, r;
   logic        crc_bit_order_high_first, wait_for_field_before_send, ext_input_polarity;
   logic        send_crc_enable, invert_send_modulation, rate_code_reserved;
   logic        rate_106, rate_212, rate_424, rate_848, misuse;
   logic [2:0]  send_bit_rate;
   logic [9:0]  kbps;
   logic [7:0]  gen_m, tx_m;
   int          error_cnt = 0, comparisons = 0, cyc = 0;
   int          kb[8] = '{106, 212, 424, 848, 0, 0, 0, 0};

   rftmc_regs i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .crc_bit_order_high_first,
      .wait_for_field_before_send, .ext_input_polarity, .crc_start_value_sel,
      .send_crc_enable, .send_bit_rate, .invert_send_modulation, .rate_106, .rate_212,
      .rate_424, .rate_848, .rate_code_reserved);
   rftmc_tx_sink i_sink (.aclk, .aresetn, .send_crc_enable, .rate_106, .rate_212,
      .rate_424, .rate_848, .kbps, .misuse);

   initial forever #5 aclk = ~aclk;

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] v, input logic [3:0] st,
                     output logic [1:0] rr);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            rr = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 0;
   endtask

   task automatic rd(input logic [9:0] a, output logic [31:0] dv, output logic [1:0] rr);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            dv = s_axi_rdata;
            rr = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 0;
   endtask

   task automatic rdchk(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
      rd(a, d, r);
      chk("rdata", d, e);
      chk("rresp", r, er);
   endtask

   task automatic outs;
      chk("gen_out", {crc_bit_order_high_first, wait_for_field_before_send, ext_input_polarity,
          crc_start_value_sel}, {gen_m[7], gen_m[5], gen_m[3], gen_m[1:0]});
      chk("tx_out", {send_crc_enable, send_bit_rate, invert_send_modulation}, tx_m[7:3]);
      chk("rate_dec", {rate_code_reserved, rate_848, rate_424, rate_212, rate_106},
          tx_m[6] ? 32'h10 : 32'h1 << tx_m[5:4]);
      chk("kbps", kbps, kb[tx_m[6:4]]);
      chk("misuse", misuse, 0);
   endtask

   initial begin
      void'($urandom(32'h8c07));
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      gen_m = rftmc_pkg::RST_GENERAL;
      tx_m = rftmc_pkg::RST_TRANSMIT;
      rdchk(rftmc_pkg::ADDR_RESERVED, rftmc_pkg::RST_RESERVED, rftmc_pkg::RESP_OKAY);
      rdchk(rftmc_pkg::ADDR_GENERAL, gen_m, rftmc_pkg::RESP_OKAY);
      rdchk(rftmc_pkg::ADDR_TRANSMIT, tx_m, rftmc_pkg::RESP_OKAY);
      outs();
      $display("reset test done");
      // Every legal rate code; CRC kept on above the slowest rate
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         d[7] = d[7] | (i != 0);
         d[6:4] = i[2:0];
         wr(rftmc_pkg::ADDR_TRANSMIT, d, 4'hf, r);
         chk("bresp", r, rftmc_pkg::RESP_OKAY);
         tx_m = d[7:0] & rftmc_pkg::TX_WMASK;
         rdchk(rftmc_pkg::ADDR_TRANSMIT, tx_m, rftmc_pkg::RESP_OKAY);
         outs();
      end
      $display("transmit test done");
      repeat (4) begin
         d = $urandom;
         wr(rftmc_pkg::ADDR_GENERAL, d, 4'hf, r);
         gen_m = (d[7:0] & rftmc_pkg::GEN_WMASK) | rftmc_pkg::GEN_FIXED;
         rdchk(rftmc_pkg::ADDR_GENERAL, gen_m, rftmc_pkg::RESP_OKAY);
         outs();
      end
      $display("general test done");
      wr(rftmc_pkg::ADDR_TRANSMIT, {24'h0, ~tx_m}, 4'he, r);
      rdchk(rftmc_pkg::ADDR_TRANSMIT, tx_m, rftmc_pkg::RESP_OKAY);
      wr(rftmc_pkg::ADDR_RESERVED, 32'hff, 4'hf, r);
      chk("bresp", r, rftmc_pkg::RESP_OKAY);
      rdchk(rftmc_pkg::ADDR_RESERVED, 32'h0, rftmc_pkg::RESP_OKAY);
      wr(10'h3fc, 32'hff, 4'hf, r);
      chk("bresp", r, rftmc_pkg::RESP_SLVERR);
      rdchk(10'h3fc, 32'h0, rftmc_pkg::RESP_SLVERR);
      outs();
      $display("refusal test done");
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
